// ### hw/eeprom_pkg.sv
// Constants, types and timing for the two-wire 16 x 8 memory slave.
// Assumes a 40 MHz core clock and a bus master driving SCL and SDA.

package eeprom_pkg;

  // Memory shape
  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned MEM_DEPTH = 16;

  // Reset values and last bit count
  localparam logic [3:0] PTR_RESET  = 4'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] CNT_RESET  = 3'h0;
  localparam logic [2:0] CNT_LAST   = 3'h7;

  // Control byte field positions
  localparam int unsigned CODE_MSB = 7;
  localparam int unsigned CODE_LSB = 4;
  localparam int unsigned RW_BIT   = 0;

  // Device code default; value is arbitrary
  localparam logic [3:0] DEV_CODE_DEFAULT = 4'h5;

  // Write cycle time
  localparam int unsigned CORE_CLK_HZ = 40000000;
  localparam int unsigned TWC_MS      = 4;
  localparam int unsigned TWC_CYCLES  = TWC_MS * (CORE_CLK_HZ / 1000);

  // Link phase, Gray along idle, receive, acknowledge, transmit, master ack
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX   = 3'h1,
    ST_ACK  = 3'h3,
    ST_TX   = 3'h2,
    ST_MACK = 3'h6
  } link_state_t;

  // Meaning of the byte being received
  typedef enum logic [1:0] {
    ROLE_CTRL = 2'h0,
    ROLE_ADDR = 2'h1,
    ROLE_DATA = 2'h3
  } byte_role_t;

endpackage

// ### hw/link_bit_capture.sv
// SCL-domain capture of SDA on each rising SCL edge, flagged by a toggle.
// Assumes SDA is stable around the SCL rise; SCL may stop between frames,
// and SCL stands idle while reset is released.
`timescale 1ns/1ps

module link_bit_capture (
  input  wire logic i_scl,
  input  wire logic i_reset,
  input  wire logic i_sda,
  output logic      o_bit,
  output logic      o_toggle
);

  // Sample data and flip the event toggle; reset acts at once, since SCL
  // may give no edge at all while reset is held
  always_ff @(posedge i_scl or posedge i_reset) begin
    if (i_reset) begin
      o_bit    <= 1'b1;
      o_toggle <= 1'b0;
    end else begin
      o_bit    <= i_sda;
      o_toggle <= ~o_toggle;
    end
  end

endmodule // link_bit_capture

// ### hw/write_cycle_timer.sv
// Self-timed write cycle counter with a busy flag.
// Assumes a one-cycle start pulse on the core clock.
`timescale 1ns/1ps

module write_cycle_timer #(
  parameter int unsigned CYCLES = 160000
) (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_start,
  output logic      o_busy
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_reg;

  if (CYCLES < 1) begin : g_bad_cycles
    $error("write cycle length must be at least one cycle");
  end

  // Load on start, count down to zero while busy
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_reg <= '0;
      o_busy  <= 1'b0;
    end else if (i_start) begin
      cnt_reg <= CW'(CYCLES - 1);
      o_busy  <= 1'b1;
    end else if (o_busy) begin
      if (cnt_reg == '0) begin
        o_busy <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

endmodule // write_cycle_timer

// ### hw/i2c_eeprom_slave_16x8.sv
// Two-wire bus slave front end and storage for a 16 x 8 memory.
// Assumes SCL and SDA from a bus master, SCL phases of at least four core
// clocks, and an external pull-up resolving SDA from the output enable.
`timescale 1ns/1ps

module i2c_eeprom_slave_16x8
  import eeprom_pkg::*;
#(
  parameter logic [3:0]  P_DEV_CODE     = eeprom_pkg::DEV_CODE_DEFAULT,
  parameter int unsigned P_WRITE_CYCLES = eeprom_pkg::TWC_CYCLES
) (
  input  wire logic I_CORE_CLK,
  input  wire logic I_RESET,
  input  wire logic I_SCL,
  input  wire logic I_SDA,
  output logic      O_SDA,
  output logic      O_SDA_OE,
  output logic      O_WRITE_BUSY
);

  import eeprom_pkg::*;

  if (P_WRITE_CYCLES < 1) begin : g_bad_write_cycles
    $error("write cycle length must be at least one cycle");
  end

  // Pin synchronisers and previous values
  logic              sda_s1_reg;
  logic              sda_s2_reg;
  logic              sda_d_reg;
  logic              scl_s1_reg;
  logic              scl_s2_reg;
  logic              scl_d_reg;

  // Bit event crossing from the SCL domain
  logic              cap_bit;
  logic              cap_toggle;
  logic              tgl_s1_reg;
  logic              tgl_s2_reg;
  logic              tgl_d_reg;

  // Decoded bus events
  logic              start_evt;
  logic              stop_evt;
  logic              scl_fall;
  logic              bit_evt;

  // Protocol state
  link_state_t       state_reg;
  byte_role_t        role_reg;
  logic [2:0]        cnt_reg;
  logic              pend_reg;
  logic              rx_bit_reg;
  logic [7:0]        rx_sh_reg;
  logic [7:0]        tx_sh_reg;
  logic              rw_reg;
  logic [ADDR_W-1:0] ptr_reg;
  logic [DATA_W-1:0] data_buf_reg;
  logic              have_data_reg;
  logic              busy;

  // Storage array
  logic [DATA_W-1:0] mem_reg [MEM_DEPTH];

  // Byte level conditions
  logic [7:0]        rx_byte;
  logic              code_ok;
  logic              byte_done;
  logic              ack_go;
  logic              ack_end;
  logic              tx_last;
  logic              mack_end;
  logic              commit;
  logic [DATA_W-1:0] rd_word;

  // Two flip-flop synchronisers for the pins
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
    end else begin
      sda_s1_reg <= I_SDA;
      sda_s2_reg <= sda_s1_reg;
      scl_s1_reg <= I_SCL;
      scl_s2_reg <= scl_s1_reg;
    end
  end

  // Delayed copies for edge detection
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      sda_d_reg <= 1'b1;
      scl_d_reg <= 1'b1;
    end else begin
      sda_d_reg <= sda_s2_reg;
      scl_d_reg <= scl_s2_reg;
    end
  end

  // SCL-domain sampler of data bits
  link_bit_capture u_capture (
    .i_scl    (I_SCL),
    .i_reset  (I_RESET),
    .i_sda    (I_SDA),
    .o_bit    (cap_bit),
    .o_toggle (cap_toggle)
  );

  // Toggle synchroniser for the bit event
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_d_reg  <= 1'b0;
    end else begin
      tgl_s1_reg <= cap_toggle;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_d_reg  <= tgl_s2_reg;
    end
  end

  // Bus conditions from the synchronised lines
  assign start_evt = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
  assign stop_evt  = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;
  assign scl_fall  = scl_d_reg & ~scl_s2_reg;
  assign bit_evt   = tgl_s2_reg ^ tgl_d_reg;

  // Byte assembly and decisions
  assign rx_byte   = {rx_sh_reg[6:0], rx_bit_reg};
  assign code_ok   = (rx_byte[CODE_MSB:CODE_LSB] == P_DEV_CODE) && !busy;
  assign byte_done = (state_reg == ST_RX) && scl_fall && pend_reg && (cnt_reg == CNT_LAST);
  assign ack_go    = byte_done && ((role_reg != ROLE_CTRL) || code_ok);
  assign ack_end   = (state_reg == ST_ACK) && scl_fall;
  assign tx_last   = (state_reg == ST_TX) && scl_fall && (cnt_reg == CNT_LAST);
  assign mack_end  = (state_reg == ST_MACK) && scl_fall && pend_reg;
  assign rd_word   = mem_reg[ptr_reg];

  // Store only a full byte-write ended by Stop on a byte boundary
  assign commit = stop_evt && (state_reg == ST_RX) && (role_reg == ROLE_DATA)
                  && have_data_reg && (cnt_reg == CNT_RESET) && !rw_reg;

  // Link phase sequencing
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      state_reg <= ST_IDLE;
    end else if (start_evt) begin
      state_reg <= ST_RX;
    end else if (stop_evt) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          state_reg <= ST_IDLE;
        end
        ST_RX: begin
          if (byte_done) begin
            state_reg <= ack_go ? ST_ACK : ST_IDLE;
          end
        end
        ST_ACK: begin
          if (ack_end) begin
            state_reg <= rw_reg ? ST_TX : ST_RX;
          end
        end
        ST_TX: begin
          if (tx_last) begin
            state_reg <= ST_MACK;
          end
        end
        ST_MACK: begin
          if (mack_end) begin
            state_reg <= rx_bit_reg ? ST_IDLE : ST_TX;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Sampled bit held until the falling SCL edge commits it
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      pend_reg   <= 1'b0;
      rx_bit_reg <= 1'b1;
    end else if (start_evt || stop_evt || scl_fall) begin
      pend_reg <= 1'b0;
    end else if (bit_evt) begin
      pend_reg   <= 1'b1;
      rx_bit_reg <= cap_bit;
    end
  end

  // Bit counter within a byte
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      cnt_reg <= CNT_RESET;
    end else if (start_evt || ack_end || mack_end) begin
      cnt_reg <= CNT_RESET;
    end else if ((state_reg == ST_RX) && scl_fall && pend_reg) begin
      cnt_reg <= cnt_reg + 3'h1;
    end else if ((state_reg == ST_TX) && scl_fall) begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end

  // Receive shift register, MSB first
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      rx_sh_reg <= BYTE_RESET;
    end else if ((state_reg == ST_RX) && scl_fall && pend_reg) begin
      rx_sh_reg <= rx_byte;
    end
  end

  // Direction bit of the control byte
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      rw_reg <= 1'b0;
    end else if (start_evt) begin
      rw_reg <= 1'b0;
    end else if (byte_done && (role_reg == ROLE_CTRL)) begin
      rw_reg <= rx_byte[RW_BIT];
    end
  end

  // Role of the next received byte in a write
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      role_reg <= ROLE_CTRL;
    end else if (start_evt) begin
      role_reg <= ROLE_CTRL;
    end else if (ack_end && !rw_reg) begin
      unique case (role_reg)
        ROLE_CTRL: role_reg <= ROLE_ADDR;
        ROLE_ADDR: role_reg <= ROLE_DATA;
        ROLE_DATA: role_reg <= ROLE_DATA;
        default:   role_reg <= ROLE_CTRL;
      endcase
    end
  end

  // Data buffer, loaded per data byte, emptied when further data bits arrive
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      have_data_reg <= 1'b0;
      data_buf_reg  <= BYTE_RESET;
    end else if (start_evt || stop_evt) begin
      have_data_reg <= 1'b0;
    end else if (byte_done && (role_reg == ROLE_DATA)) begin
      have_data_reg <= 1'b1;
      data_buf_reg  <= rx_byte;
    end else if ((state_reg == ST_RX) && (role_reg == ROLE_DATA) && scl_fall
                 && pend_reg && (cnt_reg == CNT_RESET)) begin
      have_data_reg <= 1'b0;
    end
  end

  // Address pointer: loaded by address byte, advanced per byte read
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      ptr_reg <= PTR_RESET;
    end else if (byte_done && (role_reg == ROLE_ADDR)) begin
      ptr_reg <= rx_byte[ADDR_W-1:0];
    end else if (tx_last) begin
      ptr_reg <= ptr_reg + 4'h1;
    end
  end

  // Transmit shift register
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      tx_sh_reg <= BYTE_RESET;
    end else if ((ack_end && rw_reg) || (mack_end && !rx_bit_reg)) begin
      tx_sh_reg <= rd_word;
    end else if ((state_reg == ST_TX) && scl_fall) begin
      tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
    end
  end

  // SDA pull-down: acknowledge and read data, changed only at SCL fall
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      O_SDA_OE <= 1'b0;
    end else if (start_evt || stop_evt) begin
      O_SDA_OE <= 1'b0;
    end else if (byte_done) begin
      O_SDA_OE <= ack_go;
    end else if (ack_end) begin
      O_SDA_OE <= rw_reg & ~rd_word[7];
    end else if (tx_last) begin
      O_SDA_OE <= 1'b0;
    end else if ((state_reg == ST_TX) && scl_fall) begin
      O_SDA_OE <= ~tx_sh_reg[6];
    end else if (mack_end) begin
      O_SDA_OE <= ~rx_bit_reg & ~rd_word[7];
    end
  end

  // Open-drain pin only ever pulls low
  assign O_SDA = 1'b0;

  // Memory write at the Stop that completes a byte write
  always_ff @(posedge I_CORE_CLK) begin
    if (commit) begin
      mem_reg[ptr_reg] <= data_buf_reg;
    end
  end

  // Timed write cycle; busy blocks acknowledges
  write_cycle_timer #(
    .CYCLES (P_WRITE_CYCLES)
  ) u_timer (
    .i_clk   (I_CORE_CLK),
    .i_reset (I_RESET),
    .i_start (commit),
    .o_busy  (busy)
  );

  assign O_WRITE_BUSY = busy;

endmodule // i2c_eeprom_slave_16x8

// ### bench/i2c_eeprom_slave_16x8_monitor.sv
// Checker for the two-wire memory slave, watching the top ports only.
// Assumes it is bound onto the slave; one core clock domain.
`timescale 1ns/1ps

module i2c_eeprom_slave_16x8_monitor #(
  parameter int unsigned P_WRITE_CYCLES = 160000
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  input wire logic I_SCL,
  input wire logic I_SDA,
  input wire logic O_SDA,
  input wire logic O_SDA_OE,
  input wire logic O_WRITE_BUSY
);
  logic [31:0] busy_cnt;
  logic [3:0]  since_stop;
  logic        scl_q;
  logic        sda_q;
  wire         start_ev = scl_q && I_SCL && sda_q && !I_SDA;

  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RESET);

  // Line history for Start and Stop detection
  always_ff @(posedge I_CORE_CLK) begin
    scl_q <= I_SCL;
    sda_q <= I_SDA;
  end

  // Length of the busy phase
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) busy_cnt <= '0;
    else busy_cnt <= O_WRITE_BUSY ? busy_cnt + 32'h1 : '0;
  end

  // Cycles since the last Stop, saturating
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET || (scl_q && I_SCL && !sda_q && I_SDA)) since_stop <= '0;
    else if (since_stop != 4'hF) since_stop <= since_stop + 4'h1;
  end

  a_sda_zero: assert property (O_SDA_OE |-> !O_SDA)
    else $error("SDA driven high");
  a_busy_quiet: assert property (O_WRITE_BUSY |-> !O_SDA_OE)
    else $error("SDA pulled during write cycle");
  a_oe_low_phase: assert property ($changed(O_SDA_OE) |-> !I_SCL && !scl_q)
    else $error("SDA drive changed near SCL high");
  a_oe_hold: assert property ($rose(O_SDA_OE) |-> O_SDA_OE [*8])
    else $error("SDA pull too short");
  a_oe_after_fall: assert property ($rose(O_SDA_OE) |-> $past(I_SCL, 5) && !I_SCL)
    else $error("SDA pull not after SCL fall");
  a_busy_len: assert property ($fell(O_WRITE_BUSY) |-> busy_cnt == P_WRITE_CYCLES)
    else $error("write cycle length wrong");
  a_busy_after_stop: assert property ($rose(O_WRITE_BUSY) |-> since_stop <= 4'h8)
    else $error("write cycle without Stop");
  a_start_release: assert property (start_ev |-> ##4 !O_SDA_OE)
    else $error("SDA held after Start");
endmodule // i2c_eeprom_slave_16x8_monitor

bind i2c_eeprom_slave_16x8 i2c_eeprom_slave_16x8_monitor #(
  .P_WRITE_CYCLES(P_WRITE_CYCLES)
) i2c_eeprom_slave_16x8_monitor_inst (
  .I_CORE_CLK  (I_CORE_CLK),
  .I_RESET     (I_RESET),
  .I_SCL       (I_SCL),
  .I_SDA       (I_SDA),
  .O_SDA       (O_SDA),
  .O_SDA_OE    (O_SDA_OE),
  .O_WRITE_BUSY(O_WRITE_BUSY)
);

// ### bench/twi_master.sv
// Behavioural two-wire bus master driving SCL and pulling SDA low.
// Assumes a pull-up resolves SDA; SCL stands still outside frames.
`timescale 1ns/1ps

module twi_master #(
  parameter int HALF = 150
) (
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  // Bus idles with both lines released
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // Start or repeated Start, SDA falls with SCL high
  task automatic start();
    o_sda_low = 1'b0;
    #HALF o_scl = 1'b1;
    #HALF o_sda_low = 1'b1;
    #HALF o_scl = 1'b0;
  endtask

  // Stop, SDA rises with SCL high
  task automatic stop();
    #(HALF / 2) o_sda_low = 1'b1;
    #(HALF / 2) o_scl = 1'b1;
    #HALF o_sda_low = 1'b0;
    #HALF;
  endtask

  // One clock pulse; SDA changes only while SCL low
  task automatic bit_io(input logic b, output logic s);
    #(HALF / 2) o_sda_low = ~b;
    #(HALF / 2) o_scl = 1'b1;
    #(HALF / 2) s = i_sda;
    #(HALF / 2) o_scl = 1'b0;
  endtask

  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  task automatic recv(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(~mack, s);
  endtask
endmodule // twi_master

// ### bench/i2c_eeprom_slave_16x8_tb_top.sv
// Testbench of the two-wire memory slave: writes, polling, aborts, reads.
// Assumes the master model on SCL and SDA and a pull-up on SDA.
`timescale 1ns/1ps

module i2c_eeprom_slave_16x8_tb_top;
  import eeprom_pkg::*;

  localparam int unsigned WCYC = 200;
  localparam logic [7:0]  CW   = {DEV_CODE_DEFAULT, 3'h5, 1'b0};
  localparam logic [7:0]  CR   = {DEV_CODE_DEFAULT, 3'h2, 1'b1};

  logic       clk, rst, scl, m_low, oe, sda_o, busy, ack, s;
  logic [7:0] rd;
  logic [7:0] mem [16];
  int         num_errors, compares;
  wire        sda = ~(m_low | (oe & ~sda_o));

  always #12.5 clk = ~clk;

  i2c_eeprom_slave_16x8 #(
    .P_DEV_CODE    (DEV_CODE_DEFAULT),
    .P_WRITE_CYCLES(WCYC)
  ) i2c_eeprom_slave_16x8_inst (
    .I_CORE_CLK  (clk),
    .I_RESET     (rst),
    .I_SCL       (scl),
    .I_SDA       (sda),
    .O_SDA       (sda_o),
    .O_SDA_OE    (oe),
    .O_WRITE_BUSY(busy)
  );

  twi_master twi_master_inst (.i_sda(sda), .o_scl(scl), .o_sda_low(m_low));

  task automatic stop_test();
    $display("Compares %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(string what, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  // Send a byte and compare the acknowledge
  task automatic sb(string what, logic [7:0] b, logic e);
    twi_master_inst.send(b, ack);
    chk(what, {7'h00, e}, {7'h00, ack});
  endtask

  task automatic wait_idle();
    for (int n = 0; busy !== 1'b0; n++) begin
      @(negedge clk);
      if (n > 1000) begin
        chk("busy wait", 8'h00, 8'h01);
        stop_test();
      end
    end
  endtask

  // Start, write control byte, word address
  task automatic hd(logic [7:0] a);
    twi_master_inst.start();
    sb("ctrl write", CW, 1'b1);
    sb("word addr", a, 1'b1);
  endtask

  // Busy after Stop, no answer meanwhile, answer once done
  task automatic poll();
    repeat (8) @(negedge clk);
    chk("busy", 8'h01, {7'h00, busy});
    twi_master_inst.start();
    sb("poll busy", CW, 1'b0);
    twi_master_inst.stop();
    wait_idle();
    twi_master_inst.start();
    sb("poll done", CW, 1'b1);
    twi_master_inst.stop();
  endtask

  task automatic rs(int n, logic [3:0] f);
    twi_master_inst.start();
    sb("ctrl read", CR, 1'b1);
    for (int i = 0; i < n; i++) begin
      twi_master_inst.recv(i < n - 1, rd);
      chk("read data", mem[4'(f + i)], rd);
    end
    twi_master_inst.stop();
  endtask

  task automatic t_fill();
    for (int i = 0; i < 16; i++) begin
      mem[i] = 8'(i * 29 + 90);
      hd({4'(15 - i), 4'(i)});
      sb("data", mem[i], 1'b1);
      twi_master_inst.stop();
      poll();
    end
  endtask

  task automatic t_abort();
    hd(8'h03);
    twi_master_inst.stop();
    repeat (8) @(negedge clk);
    chk("busy after addr stop", 8'h00, {7'h00, busy});
    hd(8'h03);
    sb("data", 8'hC3, 1'b1);
    sb("data", 8'h3C, 1'b1);
    for (int i = 0; i < 3; i++) twi_master_inst.bit_io(1'b0, s);
    twi_master_inst.stop();
    repeat (8) @(negedge clk);
    chk("busy after part byte", 8'h00, {7'h00, busy});
    hd(8'hF3);
    rs(1, 4'h3);
    hd(8'h63);
    sb("data", 8'h11, 1'b1);
    sb("data", 8'h22, 1'b1);
    twi_master_inst.stop();
    mem[3] = 8'h22;
    poll();
    rs(1, 4'h3);
  endtask

  task automatic t_reads();
    hd(8'h37);
    rs(1, 4'h7);
    rs(1, 4'h8);
    hd(8'hCE);
    rs(4, 4'hE);
    rs(1, 4'h2);
  endtask

  task automatic t_bad();
    for (int r = 0; r < 2; r++) begin
      twi_master_inst.start();
      sb("foreign code", {DEV_CODE_DEFAULT ^ 4'h3, 3'h0, 1'(r)}, 1'b0);
      twi_master_inst.stop();
    end
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    num_errors = 0;
    compares = 0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_fill();
    t_reads();
    t_abort();
    t_bad();
    stop_test();
  end
endmodule // i2c_eeprom_slave_16x8_tb_top
